/* logic/wdt_pkg.sv */
// Shared constants, field layouts and carrier types of the watchdog block
package wdt_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int WDT_TICK_NS     = 1000;
  localparam int TICK_CYCLES     = WDT_TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W      = 7;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);
  localparam logic [1:0] SYNC_BUS_CYCLES = 2'h2;
  localparam logic [1:0] SYNC_WDT_TICKS  = 2'h2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] CLEAR_OFFSET  = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] MASK_OFFSET   = 8'h0C;
  localparam logic [ADDR_W-1:0] COUNT_OFFSET  = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_W          = 5;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CTRL_PSEL_LSB  = 2;
  localparam int CTRL_BAND_LSB  = 7;
  localparam int CLEAR_BIT      = 0;
  localparam int STATUS_W       = 5;
  localparam int ST_LATE_CLEAR  = 0;
  localparam int ST_TIMEOUT     = 1;
  localparam int ST_RESET       = 2;
  localparam int ST_EN_SYNCED   = 3;
  localparam int ST_EARLY_CLEAR = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [STATUS_W-1:0] STATUS_RST = 5'h00;
  localparam logic [STATUS_W-1:0] MASK_RST   = 5'h00;
  localparam logic [DATA_W-1:0]   COUNT_RST  = 32'h00000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0] time_band_prescale_select;
    logic [SEL_W-1:0] timeout_prescale_select;
    logic             mode;
    logic             enable;
  } ctrl_fields_type;

  localparam ctrl_fields_type CTRL_RST = '{default: '0};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_type;

  typedef enum logic [0:0] {
    SYNC_IDLE = 1'b0,
    SYNC_BUSY = 1'b1
  } sync_state_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] low_mask(input logic [SEL_W-1:0] sel);
    low_mask = (32'h00000001 << sel) - 32'h00000001;
  endfunction : low_mask

  function automatic ctrl_fields_type ctrl_unpack(input logic [DATA_W-1:0] w);
    ctrl_unpack.enable                    = w[CTRL_EN_BIT];
    ctrl_unpack.mode                      = w[CTRL_MODE_BIT];
    ctrl_unpack.timeout_prescale_select   = w[CTRL_PSEL_LSB +: SEL_W];
    ctrl_unpack.time_band_prescale_select = w[CTRL_BAND_LSB +: SEL_W];
  endfunction : ctrl_unpack

  function automatic logic [DATA_W-1:0] ctrl_pack(input ctrl_fields_type f);
    ctrl_pack                         = '0;
    ctrl_pack[CTRL_EN_BIT]            = f.enable;
    ctrl_pack[CTRL_MODE_BIT]          = f.mode;
    ctrl_pack[CTRL_PSEL_LSB +: SEL_W] = f.timeout_prescale_select;
    ctrl_pack[CTRL_BAND_LSB +: SEL_W] = f.time_band_prescale_select;
  endfunction : ctrl_pack

endpackage : wdt_pkg

/* logic/wdt_tick_div.sv */
// Divider making the watchdog tick enable from the system clock
`timescale 1ns/100ps
module wdt_tick_div (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // Tick
  output logic      o_tick
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic                  tick;
  } div_state_type;

  div_state_type st_reg;
  div_state_type st_next;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == TICK_LAST) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

endmodule : wdt_tick_div

/* logic/wdt_ctrl_sync.sv */
// Carries written control fields into the watchdog tick domain
`timescale 1ns/100ps
module wdt_ctrl_sync (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  // Write side
  input  wire logic                     i_start,
  input  wdt_pkg::ctrl_fields_type      i_fields,
  input  wire logic                     i_tick,
  // Watchdog side
  output wdt_pkg::ctrl_fields_type      o_active,
  output logic                          o_busy,
  output logic                          o_en_done
);
  import wdt_pkg::*;

  typedef struct packed {
    sync_state_type  state;
    ctrl_fields_type pend;
    ctrl_fields_type active;
    logic [1:0]      bus_cnt;
    logic [1:0]      tick_cnt;
    logic            en_done;
  } sync_reg_type;

  localparam sync_reg_type SYNC_RST = '{
    state: SYNC_IDLE, pend: CTRL_RST, active: CTRL_RST,
    bus_cnt: 2'h0, tick_cnt: 2'h0, en_done: 1'b0};

  sync_reg_type st_reg;
  sync_reg_type st_next;

  // ----------------------------------------------------------------
  // Transfer sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.en_done = 1'b0;
    unique case (st_reg.state)
      SYNC_IDLE: begin
        // R1: write starts transfer
        if (i_start) begin
          st_next.pend     = i_fields;
          st_next.bus_cnt  = 2'h0;
          st_next.tick_cnt = 2'h0;
          st_next.state    = SYNC_BUSY;
        end
      end
      SYNC_BUSY: begin
        if (st_reg.bus_cnt != SYNC_BUS_CYCLES) begin
          st_next.bus_cnt = st_reg.bus_cnt + 2'h1;
        end
        if (i_tick && st_reg.tick_cnt != SYNC_WDT_TICKS) begin
          st_next.tick_cnt = st_reg.tick_cnt + 2'h1;
        end
        // R1: apply after both waits
        if (st_reg.bus_cnt == SYNC_BUS_CYCLES && st_reg.tick_cnt == SYNC_WDT_TICKS) begin
          st_next.active  = st_reg.pend;
          // R2: only enable reports done
          st_next.en_done = st_reg.pend.enable != st_reg.active.enable;
          st_next.state   = SYNC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_reg <= SYNC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_active  = st_reg.active;
  assign o_busy    = st_reg.state == SYNC_BUSY;
  assign o_en_done = st_reg.en_done;

endmodule : wdt_ctrl_sync

/* logic/watchdog_ctrl_sync.sv */
// Watchdog timer with synchronized control, clear checks and interrupt
//
// How it works
// R1: A write to the timeout select, time band select, enable or mode field starts a transfer.
// R2: Only the enable field shows that its transfer is done; the others show the written value.
// R3: Software must not rewrite these fields during a transfer; such writes are dropped here.
// R4: Software waits two bus cycles and two watchdog ticks before writing them again.
// R5: The enable bit reads its old value until the transfer ends, so software can poll it.
// R6: A clear in the second half of the timeout period raises the watchdog reset at once.
// R7: Software programs twice the needed timeout and clears only in the first half.
// R8: Without clears the reset comes exactly when the full timeout period has run out.
// R9: The counter steps on each watchdog tick while enabled and returns to zero at period end; a valid clear restarts it at zero.
// R10: The half of the period is the counter bit picked by the timeout select.
`timescale 1ns/100ps
module watchdog_ctrl_sync (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  // Register port
  input  wdt_pkg::bus_req_type          i_bus,
  output logic [wdt_pkg::DATA_W-1:0]    o_rdata,
  // Watchdog outputs
  output logic                          o_wdt_reset,
  output logic                          o_irq
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_fields_type     written;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic [DATA_W-1:0]   count;
    logic [DATA_W-1:0]   rdata;
    logic                reset_req;
  } wdt_state_type;

  localparam wdt_state_type WDT_RST = '{
    written: CTRL_RST, status: STATUS_RST, mask: MASK_RST,
    count: COUNT_RST, rdata: '0, reset_req: 1'b0};

  wdt_state_type   st_reg;
  wdt_state_type   st_next;
  ctrl_fields_type active;
  ctrl_fields_type shown;
  logic            tick;
  logic            sync_busy;
  logic            en_done;
  logic            ctrl_wr;
  logic            sync_start;
  logic            clear_wr;
  logic            second_half;
  logic            too_early;
  logic            period_end;
  logic [DATA_W-1:0]   psel_mask;
  logic [DATA_W-1:0]   band_mask;
  logic [STATUS_W-1:0] events;
  logic [STATUS_W-1:0] w1c;

  // ----------------------------------------------------------------
  // Watchdog tick
  // ----------------------------------------------------------------
  wdt_tick_div u_tick_div (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  // ----------------------------------------------------------------
  // Control transfer
  // ----------------------------------------------------------------
  assign ctrl_wr = i_bus.wr && i_bus.addr == CTRL_OFFSET;
  // R3: drop writes during transfer
  assign sync_start = ctrl_wr && !sync_busy;

  wdt_ctrl_sync u_ctrl_sync (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_start   (sync_start),
    .i_fields  (ctrl_unpack(i_bus.wdata)),
    .i_tick    (tick),
    .o_active  (active),
    .o_busy    (sync_busy),
    .o_en_done (en_done)
  );

  // ----------------------------------------------------------------
  // Period decode
  // ----------------------------------------------------------------
  assign psel_mask = low_mask(active.timeout_prescale_select);
  assign band_mask = low_mask(active.time_band_prescale_select);
  // R10: half from selected bit
  assign second_half = st_reg.count[active.timeout_prescale_select];
  // R8: full period reached
  assign period_end = second_half && (st_reg.count & psel_mask) == psel_mask;
  assign too_early = active.mode && st_reg.count < band_mask;

  assign clear_wr = i_bus.wr && i_bus.addr == CLEAR_OFFSET && i_bus.wdata[CLEAR_BIT];

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    if (active.enable && clear_wr) begin
      // R6: late clear resets at once
      if (second_half) begin
        events[ST_LATE_CLEAR] = 1'b1;
        events[ST_RESET]      = 1'b1;
      end else if (too_early) begin
        events[ST_EARLY_CLEAR] = 1'b1;
        events[ST_RESET]       = 1'b1;
      end
    end else if (active.enable && tick && period_end) begin
      events[ST_TIMEOUT] = 1'b1;
      events[ST_RESET]   = 1'b1;
    end
    // R2: enable transfer done
    events[ST_EN_SYNCED] = en_done;
  end

  assign w1c = (i_bus.wr && i_bus.addr == STATUS_OFFSET) ? i_bus.wdata[STATUS_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Read view of control
  // ----------------------------------------------------------------
  always_comb begin
    shown        = st_reg.written;
    // R5: enable reads old value
    shown.enable = active.enable;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // R1: keep written fields
    if (sync_start) begin
      st_next.written = ctrl_unpack(i_bus.wdata);
    end
    if (i_bus.wr && i_bus.addr == MASK_OFFSET) begin
      st_next.mask = i_bus.wdata[STATUS_W-1:0];
    end

    // Set wins over clear
    st_next.status = (st_reg.status & ~w1c) | events;

    if (events[ST_RESET]) begin
      st_next.reset_req = 1'b1;
    end

    // R9: count, restart on valid clear
    if (!active.enable) begin
      st_next.count = COUNT_RST;
    end else if (clear_wr) begin
      if (!events[ST_RESET]) begin
        st_next.count = COUNT_RST;
      end
    end else if (tick) begin
      if (period_end) begin
        st_next.count = COUNT_RST;
      end else begin
        st_next.count = st_reg.count + 32'h00000001;
      end
    end

    st_next.rdata = '0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        CTRL_OFFSET:   st_next.rdata = ctrl_pack(shown);
        STATUS_OFFSET: st_next.rdata = {{(DATA_W-STATUS_W){1'b0}}, st_reg.status};
        MASK_OFFSET:   st_next.rdata = {{(DATA_W-STATUS_W){1'b0}}, st_reg.mask};
        COUNT_OFFSET:  st_next.rdata = st_reg.count;
        default:       st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_reg <= WDT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata     = st_reg.rdata;
  // R6: reset request held
  assign o_wdt_reset = st_reg.reset_req;
  assign o_irq       = |(st_reg.status & st_reg.mask);

endmodule : watchdog_ctrl_sync

/* tb/watchdog_ctrl_sync_properties.sv */
// Port checker for the watchdog control and clear block
`timescale 1ns/100ps
module watchdog_ctrl_sync_properties (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  // Register port
  input  wdt_pkg::bus_req_type       i_bus,
  input  wire logic [wdt_pkg::DATA_W-1:0] o_rdata,
  // Watchdog outputs
  input  wire logic                  o_wdt_reset,
  input  wire logic                  o_irq
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [9:0] since_rst;
  logic       mapped;

  assign mapped = i_bus.addr inside {CTRL_OFFSET, CLEAR_OFFSET, STATUS_OFFSET,
                                     MASK_OFFSET, COUNT_OFFSET};

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      since_rst <= 10'h000;
    end else if (since_rst != 10'h3FF) begin
      since_rst <= since_rst + 10'h001;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RDATA_IDLE: assert property (!i_bus.rd |=> o_rdata == '0)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED_ZERO: assert property (i_bus.rd && !mapped |=> o_rdata == '0)
    else $error("unmapped read returned data");
  AST_RESET_STICKY: assert property (o_wdt_reset |=> o_wdt_reset)
    else $error("watchdog reset dropped");
  AST_OUTS_AFTER_RST: assert property ($rose(i_rst_n) |-> !o_wdt_reset && !o_irq)
    else $error("outputs active after reset");
  AST_RESET_NOT_EARLY: assert property (since_rst < 10'h0F0 |-> !o_wdt_reset)
    else $error("watchdog reset before any full period");
  AST_EN_SYNC_DELAY: assert property (
    i_bus.rd && i_bus.addr == CTRL_OFFSET && since_rst < 10'h0F0 |=> !o_rdata[0])
    else $error("enable shown before its transfer could end");
  AST_IRQ_HOLD: assert property (o_irq && !i_bus.wr |=> o_irq)
    else $error("interrupt dropped without a write");
  AST_MASK_OFF_IRQ: assert property (
    i_bus.wr && i_bus.addr == MASK_OFFSET && i_bus.wdata[4:0] == 5'h00 |=> !o_irq)
    else $error("interrupt high with all sources masked");

  cover property ($rose(o_wdt_reset));
  cover property (i_bus.rd && i_bus.addr == CTRL_OFFSET ##1 o_rdata[0]);
  cover property ($fell(o_irq));
endmodule : watchdog_ctrl_sync_properties

bind watchdog_ctrl_sync watchdog_ctrl_sync_properties u_props (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .o_wdt_reset(o_wdt_reset), .o_irq(o_irq));

/* tb/watchdog_ctrl_sync_tb_top.sv */
// Self-checking bench for the watchdog control and clear block
`timescale 1ns/100ps
module watchdog_ctrl_sync_tb_top;
  import wdt_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] care;
  } note_type;

  logic              i_clock = 1'b0;
  logic              i_rst_n = 1'b0;
  bus_req_type       i_bus   = '0;
  logic [DATA_W-1:0] o_rdata;
  logic              o_wdt_reset;
  logic              o_irq;
  note_type          notes[$];
  note_type          note;
  logic              rd_taken = 1'b0;
  logic [DATA_W-1:0] last_rd;
  logic [31:0]       lfsr = 32'hCFFA;
  int                fails = 0;
  int                checked = 0;
  int                n;

  always #4 i_clock = ~i_clock;

  watchdog_ctrl_sync dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_wdt_reset(o_wdt_reset), .o_irq(o_irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic do_reset();
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clock);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    i_bus <= '0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                    input logic [DATA_W-1:0] m);
    notes.push_back('{value: v, care: m});
    @(posedge i_clock);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge i_clock);
    i_bus <= '0;
    #1 last_rd = o_rdata;
  endtask : rd

  task automatic wait_val(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                          input logic [DATA_W-1:0] m);
    int k;
    k = 0;
    do begin
      rd(a, '0, '0);
      k++;
    end while ((last_rd & m) !== v && k < 600);
    check("poll", last_rd & m, v);
  endtask : wait_val

  task automatic clear_at(input logic [DATA_W-1:0] c, input logic hit);
    wait_val(COUNT_OFFSET, c, '1);
    wr(CLEAR_OFFSET, 32'h1);
    @(posedge i_clock);
    #1 check("clear reset", 32'(o_wdt_reset), 32'(hit));
    if (!hit) rd(COUNT_OFFSET, '0, '1);
  endtask : clear_at

  // ----------------------------------------------------------------
  // Read result monitor
  // ----------------------------------------------------------------
  always @(posedge i_clock) rd_taken <= i_bus.rd & i_rst_n;
  always @(negedge i_clock) begin
    if (rd_taken && notes.size() > 0) begin
      note = notes.pop_front();
      check("read data", o_rdata & note.care, note.value & note.care);
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd(CTRL_OFFSET, '0, '1);
    rd(STATUS_OFFSET, '0, '1);
    rd(COUNT_OFFSET, '0, '1);
    rd(8'h20, '0, '1);
    wr(MASK_OFFSET, 32'h1F);
    rd(MASK_OFFSET, 32'h1F, '1);
    lfsr = lfsr_next(lfsr);
    wr(CTRL_OFFSET, {20'h0, lfsr[4:0], 5'h01, 2'b01});
    wr(CTRL_OFFSET, {20'h0, ~lfsr[4:0], 5'h03, 2'b10});
    rd(CTRL_OFFSET, {20'h0, lfsr[4:0], 5'h01, 2'b00}, '1);
    wait_val(CTRL_OFFSET, 32'h1, 32'h1);
    rd(STATUS_OFFSET, 32'h8, 32'h1F);
    check("irq", 32'(o_irq), 32'h1);
    wr(STATUS_OFFSET, 32'h8);
    #1 check("irq", 32'(o_irq), 32'h0);
    clear_at(32'h1, 1'b0);
    clear_at(32'h2, 1'b1);
    rd(STATUS_OFFSET, 32'h5, 32'h1F);
    check("irq", 32'(o_irq), 32'h1);
    wr(MASK_OFFSET, '0);
    #1 check("irq", 32'(o_irq), 32'h0);
    do_reset();
    #1 check("reset", 32'(o_wdt_reset), 32'h0);
    lfsr = lfsr_next(lfsr);
    wr(CTRL_OFFSET, {20'h0, lfsr[4:0], 5'h02, 2'b01});
    wait_val(CTRL_OFFSET, 32'h1, 32'h1);
    clear_at(32'h2, 1'b0);
    wait_val(COUNT_OFFSET, 32'h7, '1);
    check("early", 32'(o_wdt_reset), 32'h0);
    n = 0;
    while (o_wdt_reset !== 1'b1 && n < 130) begin
      @(posedge i_clock);
      #1 n++;
    end
    check("timeout", 32'(o_wdt_reset), 32'h1);
    rd(STATUS_OFFSET, 32'h6, 32'h7);
    do_reset();
    wr(MASK_OFFSET, 32'h10);
    wr(CTRL_OFFSET, {20'h0, 5'h02, 5'h02, 2'b11});
    wait_val(CTRL_OFFSET, 32'h1, 32'h1);
    clear_at(32'h1, 1'b1);
    rd(STATUS_OFFSET, 32'h14, 32'h17);
    check("irq", 32'(o_irq), 32'h1);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    conclude();
  end
endmodule : watchdog_ctrl_sync_tb_top
